/* rtl/adc_conversion_sequencer.sv */
// Conversion sequencer: clock select, start/abort, result justification, trigger start, registers
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module adc_conversion_sequencer (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    sys_rst,
    // Register bus
    input  wire adc_seq_pkg::avmm_req_s  avs_req,
    output      adc_seq_pkg::avmm_rsp_s  avs_rsp,
    // Analog front end
    input  wire logic                    sar_cmp_in,
    input  wire logic                    rc_clk_in,
    output      adc_seq_pkg::analog_ctl_s analog_ctl,
    // Compare unit trigger and timer
    input  wire logic                    special_trig,
    output      logic                    timer_clear,
    // Interrupt
    output      logic                    irq
);
    import adc_seq_pkg::*;

    seq_state_e  state_r;
    seq_state_e  state_nxt;
    logic [7:0]  control_r;
    logic [7:0]  config_r;
    logic [7:0]  res_high_r;
    logic [7:0]  res_low_r;
    logic [1:0]  status_r;
    logic [1:0]  mask_r;
    logic [3:0]  trig_cfg_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic [5:0]  div_cnt_r;
    logic [3:0]  tad_cnt_r;
    logic [9:0]  code_r;
    logic [9:0]  bit_mask_r;
    logic        rc_s1_r;
    logic        rc_s2_r;
    logic        rc_s3_r;
    logic        timer_clear_r;
    logic [6:0]  div_max;

    // Bus decode
    wire        bus_req    = avs_req.read | avs_req.write;
    wire        bus_fire   = bus_req & ack_r;
    wire        wr_fire    = avs_req.write & ack_r;
    wire [7:0]  wdat       = avs_req.writedata[7:0];
    wire        wr_high    = wr_fire & (avs_req.address == OFS_RESULT_HIGH);
    wire        wr_low     = wr_fire & (avs_req.address == OFS_RESULT_LOW);
    wire        wr_ctl     = wr_fire & (avs_req.address == OFS_CONTROL);
    wire        wr_cfg     = wr_fire & (avs_req.address == OFS_CONFIG);
    wire        wr_stat    = wr_fire & (avs_req.address == OFS_IRQ_STATUS);
    wire        wr_mask    = wr_fire & (avs_req.address == OFS_IRQ_MASK);
    wire        wr_trig    = wr_fire & (avs_req.address == OFS_TRIG_CFG);

    // Control fields
    wire        conv_on    = control_r[CTL_ON_BIT];
    wire        go_flag    = control_r[CTL_GO_BIT];
    wire [2:0]  conv_clock_sel = {config_r[CFG_CLKSEL2], control_r[CTL_CLKSEL_LSB +: 2]};
    wire        rc_mode    = (conv_clock_sel[1:0] == 2'b11);
    wire        result_format_sel = config_r[CFG_FMT_BIT];

    // Trigger qualification
    wire        trig_armed = special_trig & (trig_cfg_r == SPECIAL_EVENT_MODE);
    wire        hw_start   = trig_armed & conv_on & (state_r == ST_IDLE);

    // Software go handling
    wire        new_on     = wr_ctl ? wdat[CTL_ON_BIT] : conv_on;
    wire        sw_start   = wr_ctl & wdat[CTL_GO_BIT] & conv_on & (state_r == ST_IDLE);
    wire        off_abort  = ~new_on & (state_r != ST_IDLE);
    wire        start      = (sw_start | hw_start) & new_on;

    // Bit-period enable
    wire        rc_edge    = rc_s2_r & ~rc_s3_r;
    wire        div_wrap   = ({1'b0, div_cnt_r} == div_max - 7'h01);
    wire        div_tick   = rc_mode ? rc_edge : div_wrap;
    wire        running    = (state_r != ST_IDLE);
    wire        tad_en     = running & div_tick;
    wire        conv_last  = (state_r == ST_CONV) & tad_en & (tad_cnt_r == CONV_TADS - 4'h1);
    wire        abort_last = (state_r == ST_ABORT) & tad_en & (tad_cnt_r == ABORT_TADS - 4'h1);
    wire        sw_abort   = wr_ctl & ~wdat[CTL_GO_BIT] & (state_r == ST_CONV) & ~conv_last;
    wire        bit_step   = (state_r == ST_CONV) & tad_en & (tad_cnt_r >= FIRST_BIT_TAD);

    // SAR decision
    wire [9:0]  code_kept  = sar_cmp_in ? code_r : (code_r & ~bit_mask_r);
    wire [9:0]  mask_shift = bit_mask_r >> 1;
    wire [9:0]  final_code = code_kept;

    // Justified result
    wire [7:0]  just_high  = result_format_sel ? {6'h00, final_code[9:8]} : final_code[9:2];
    wire [7:0]  just_low   = result_format_sel ? final_code[7:0] : {final_code[1:0], 6'h00};

    // Interrupt events
    wire [1:0]  irq_events = {trig_armed, conv_last};
    wire [1:0]  status_nxt = irq_events | (status_r & ~(wr_stat ? wdat[1:0] : 2'h0));

    // Read mux
    wire [7:0]  rd_byte =
        (avs_req.address == OFS_RESULT_HIGH) ? res_high_r :
        (avs_req.address == OFS_RESULT_LOW)  ? res_low_r  :
        (avs_req.address == OFS_CONTROL)     ? {control_r[7:2], 1'b0, control_r[0]} :
        (avs_req.address == OFS_CONFIG)      ? {config_r[7:6], 2'b00, config_r[3:0]} :
        (avs_req.address == OFS_IRQ_STATUS)  ? {6'h00, status_r} :
        (avs_req.address == OFS_IRQ_MASK)    ? {6'h00, mask_r} :
        (avs_req.address == OFS_TRIG_CFG)    ? {4'h0, trig_cfg_r} : 8'h00;

    // Divider reload selection
    always_comb begin
        case (conv_clock_sel)
            3'b000:  div_max = DIV_2;
            3'b100:  div_max = DIV_4;
            3'b001:  div_max = DIV_8;
            3'b101:  div_max = DIV_16;
            3'b010:  div_max = DIV_32;
            3'b110:  div_max = DIV_64;
            default: div_max = DIV_2;
        endcase
    end

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (off_abort) begin
                    state_nxt = ST_IDLE;
                end else if (sw_abort) begin
                    state_nxt = ST_ABORT;
                end else if (conv_last) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ABORT: begin
                if (off_abort || abort_last) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Bus handshake and read data
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= bus_req & ~ack_r;
            rdata_r <= {24'h00_0000, rd_byte};
        end
    end

    // Sequencer state and bit-period counters
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r   <= ST_IDLE;
            div_cnt_r <= 6'h00;
            tad_cnt_r <= 4'h0;
        end else begin
            state_r   <= state_nxt;
            if (!running || div_tick || (state_nxt != state_r)) begin
                div_cnt_r <= 6'h00;
            end else begin
                div_cnt_r <= div_cnt_r + 6'h01;
            end
            if (state_nxt != state_r) begin
                tad_cnt_r <= 4'h0;
            end else if (tad_en) begin
                tad_cnt_r <= tad_cnt_r + 4'h1;
            end
        end
    end

    // RC source synchroniser
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rc_s1_r <= 1'b0;
            rc_s2_r <= 1'b0;
            rc_s3_r <= 1'b0;
        end else begin
            rc_s1_r <= rc_clk_in;
            rc_s2_r <= rc_s1_r;
            rc_s3_r <= rc_s2_r;
        end
    end

    // Successive approximation
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            code_r     <= 10'h000;
            bit_mask_r <= 10'h000;
        end else if (start && state_r == ST_IDLE) begin
            code_r     <= 10'h000;
            bit_mask_r <= 10'h000;
        end else if ((state_r == ST_CONV) && tad_en && (tad_cnt_r == FIRST_BIT_TAD - 4'h1)) begin
            code_r     <= 10'h200;
            bit_mask_r <= 10'h200;
        end else if (bit_step) begin
            code_r     <= code_kept | mask_shift;
            bit_mask_r <= mask_shift;
        end
    end

    // Control, configuration and trigger registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            control_r  <= CONTROL_RST;
            config_r   <= CONFIG_RST;
            trig_cfg_r <= TRIG_RST;
            mask_r     <= IRQ_RST;
        end else begin
            if (wr_ctl) begin
                control_r <= {wdat[7:3], go_flag & wdat[CTL_GO_BIT], 1'b0, wdat[CTL_ON_BIT]};
            end
            if (start) begin
                control_r[CTL_GO_BIT] <= 1'b1;
            end else if (conv_last || off_abort) begin
                control_r[CTL_GO_BIT] <= 1'b0;
            end else if (!wr_ctl) begin
                control_r[CTL_GO_BIT] <= go_flag & (state_r == ST_CONV);
            end
            if (wr_cfg) begin
                config_r <= {wdat[7:6], 2'b00, wdat[3:0]};
            end
            if (wr_trig) begin
                trig_cfg_r <= wdat[3:0];
            end
            if (wr_mask) begin
                mask_r <= wdat[1:0];
            end
        end
    end

    // Result pair and interrupt status
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            res_high_r    <= RESULT_RST;
            res_low_r     <= RESULT_RST;
            status_r      <= IRQ_RST;
            timer_clear_r <= 1'b0;
        end else begin
            if (conv_last) begin
                res_high_r <= just_high;
                res_low_r  <= just_low;
            end else begin
                if (wr_high) begin
                    res_high_r <= wdat;
                end
                if (wr_low) begin
                    res_low_r <= wdat;
                end
            end
            status_r      <= status_nxt;
            timer_clear_r <= trig_armed;
        end
    end

    // Outputs
    assign avs_rsp.waitrequest     = bus_req & ~ack_r;
    assign avs_rsp.readdata        = rdata_r;
    assign analog_ctl.channel_sel  = control_r[CTL_CHAN_LSB +: 3];
    assign analog_ctl.converter_on = conv_on;
    assign analog_ctl.acquire      = conv_on & (state_r == ST_IDLE);
    assign analog_ctl.trial_code   = code_r;
    assign timer_clear             = timer_clear_r;
    assign irq                     = |(status_r & mask_r);

    // Checks
    property p_done_clears_go;
        @(posedge mclk) disable iff (sys_rst)
        conv_last && !off_abort |=> !go_flag && status_r[IRQ_DONE_BIT] && state_r == ST_IDLE;
    endproperty
    a_done_clears_go: assert property (p_done_clears_go) else $error("done did not clear go");

    property p_abort_keeps_result;
        @(posedge mclk) disable iff (sys_rst)
        sw_abort && !off_abort && !wr_high && !wr_low |=> $stable(res_high_r) && $stable(res_low_r);
    endproperty
    a_abort_keeps_result: assert property (p_abort_keeps_result) else $error("abort changed result");

    property p_abort_wait;
        @(posedge mclk) disable iff (sys_rst)
        $rose(state_r == ST_ABORT) |-> (state_r == ST_ABORT) throughout (!tad_en [*1] ##0 1'b1)
            or (state_r == ST_ABORT && tad_cnt_r == 4'h0);
    endproperty
    a_abort_wait: assert property (p_abort_wait) else $error("abort wait entered wrong");

    property p_abort_two_tad;
        @(posedge mclk) disable iff (sys_rst)
        state_r == ST_ABORT && tad_en && tad_cnt_r == 4'h0 && !off_abort |=> state_r == ST_ABORT;
    endproperty
    a_abort_two_tad: assert property (p_abort_two_tad) else $error("abort wait shorter than two periods");

    property p_conv_len;
        @(posedge mclk) disable iff (sys_rst)
        state_r == ST_CONV |-> tad_cnt_r < CONV_TADS;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion exceeded twelve periods");

    property p_right_just;
        @(posedge mclk) disable iff (sys_rst)
        conv_last && result_format_sel |=> res_high_r[7:2] == 6'h00;
    endproperty
    a_right_just: assert property (p_right_just) else $error("right justified high bits not zero");

    property p_left_just;
        @(posedge mclk) disable iff (sys_rst)
        conv_last && !result_format_sel |=> res_low_r[5:0] == 6'h00;
    endproperty
    a_left_just: assert property (p_left_just) else $error("left justified low bits not zero");

    property p_trig_start;
        @(posedge mclk) disable iff (sys_rst)
        hw_start && !wr_ctl |=> go_flag && state_r == ST_CONV && timer_clear;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

    property p_trig_off;
        @(posedge mclk) disable iff (sys_rst)
        trig_armed && !conv_on && !wr_ctl |=> timer_clear && !go_flag && state_r == ST_IDLE;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("trigger acted while off");

    property p_div_period;
        @(posedge mclk) disable iff (sys_rst)
        running && !rc_mode && conv_clock_sel == 3'b000 && $stable(state_r) && div_tick
            |=> !div_tick ##1 (div_tick || state_r == ST_IDLE || $changed(state_r) || $changed(conv_clock_sel));
    endproperty
    a_div_period: assert property (p_div_period) else $error("two-cycle bit period wrong");

    property p_reset_clears;
        @(posedge mclk) sys_rst |=> control_r == CONTROL_RST && state_r == ST_IDLE;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left converter active");

    property p_irq_level;
        @(posedge mclk) disable iff (sys_rst)
        status_r[IRQ_DONE_BIT] && mask_r[IRQ_DONE_BIT] |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not raised");
endmodule

/* rtl/adc_seq_pkg.sv */
// Package with register map, field layout, timing and bus carrier types for the conversion sequencer
package adc_seq_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_RESULT_HIGH = 5'h00;
    localparam logic [4:0] OFS_RESULT_LOW  = 5'h04;
    localparam logic [4:0] OFS_CONTROL     = 5'h08;
    localparam logic [4:0] OFS_CONFIG      = 5'h0C;
    localparam logic [4:0] OFS_IRQ_STATUS  = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK    = 5'h14;
    localparam logic [4:0] OFS_TRIG_CFG    = 5'h18;
    // Control fields
    localparam int CTL_CLKSEL_LSB = 6;
    localparam int CTL_CHAN_LSB   = 3;
    localparam int CTL_GO_BIT     = 2;
    localparam int CTL_ON_BIT     = 0;
    // Config fields
    localparam int CFG_FMT_BIT    = 7;
    localparam int CFG_CLKSEL2    = 6;
    // Interrupt bits
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_TRIG_BIT   = 1;
    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST  = 8'h00;
    localparam logic [7:0] RESULT_RST  = 8'h00;
    localparam logic [1:0] IRQ_RST     = 2'h0;
    localparam logic [3:0] TRIG_RST    = 4'h0;
    // Compare mode that arms the hardware start
    localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;
    // Timing in conversion bit periods
    localparam logic [3:0] CONV_TADS  = 4'hC;
    localparam logic [3:0] ABORT_TADS = 4'h2;
    localparam logic [3:0] FIRST_BIT_TAD = 4'h1;
    // Divider reload values in system clock periods
    localparam logic [6:0] DIV_2  = 7'h02;
    localparam logic [6:0] DIV_4  = 7'h04;
    localparam logic [6:0] DIV_8  = 7'h08;
    localparam logic [6:0] DIV_16 = 7'h10;
    localparam logic [6:0] DIV_32 = 7'h20;
    localparam logic [6:0] DIV_64 = 7'h40;

    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ABORT} seq_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } avmm_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avmm_rsp_s;

    typedef struct packed {
        logic [2:0] channel_sel;
        logic       converter_on;
        logic       acquire;
        logic [9:0] trial_code;
    } analog_ctl_s;
endpackage

/* sim/adc_conversion_sequencer_tb_top.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module adc_conversion_sequencer_tb_top;
    import adc_seq_pkg::*;
    logic        mclk;
    logic        sys_rst;
    avmm_req_s   avs_req;
    avmm_rsp_s   avs_rsp;
    logic        sar_cmp_in;
    logic        rc_clk_in;
    analog_ctl_s analog_ctl;
    logic        special_trig;
    logic        timer_clear;
    logic        irq;
    logic [9:0]  vin;
    logic [7:0]  q;
    logic [7:0]  ctl;
    int          n_errors;
    int          comparisons;
    int          cycles_run;
    int          cyc;
    int          exp_hi;
    int          exp_lo;
    int          sel_tab[6] = '{0, 4, 1, 5, 2, 6};
    int          div_tab[6] = '{2, 4, 8, 16, 32, 64};

    adc_conversion_sequencer DUT (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .avs_req      (avs_req),
        .avs_rsp      (avs_rsp),
        .sar_cmp_in   (sar_cmp_in),
        .rc_clk_in    (rc_clk_in),
        .analog_ctl   (analog_ctl),
        .special_trig (special_trig),
        .timer_clear  (timer_clear),
        .irq          (irq)
    );

    always #4 mclk = ~mclk;
    // Ideal comparator against the trial code
    always @(posedge mclk) sar_cmp_in <= (vin >= analog_ctl.trial_code);
    always @(posedge mclk) begin
        cycles_run++;
        // RC source stand-in, six clocks a period
        if (cycles_run % 3 == 0)
            rc_clk_in <= ~rc_clk_in;
        if (cycles_run == 60000) begin
            n_errors++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // One bus access, held until waitrequest is seen low
    task bus(input bit wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] r);
        avs_req.read      <= !wr;
        avs_req.write     <= wr;
        avs_req.address   <= a;
        avs_req.writedata <= {24'h000000, d};
        @(posedge mclk);
        while (avs_rsp.waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        r = avs_rsp.readdata[7:0];
        avs_req.read  <= 1'b0;
        avs_req.write <= 1'b0;
        @(posedge mclk);
    endtask

    task wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask

    task rd_chk(input logic [4:0] a, input logic [7:0] e, input string nm);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        check(nm, r, e);
    endtask

    // Cycles until irq (or acquire) is seen high
    task wait_sig(input bit use_acq, output int c);
        c = 0;
        @(negedge mclk);
        while (((use_acq ? analog_ctl.acquire : irq) !== 1'b1) && c < 3000) begin
            @(negedge mclk);
            c++;
        end
        @(posedge mclk);
    endtask

    task set_exp(input logic [9:0] v, input logic fmt);
        exp_hi = fmt ? {6'h00, v[9:8]} : v[9:2];
        exp_lo = fmt ? v[7:0] : {v[1:0], 6'h00};
    endtask

    task trig_pulse(input logic e);
        special_trig <= 1'b1;
        @(posedge mclk);
        special_trig <= 1'b0;
        @(negedge mclk);
        check("timer_clear", timer_clear, e);
        @(negedge mclk);
        check("timer_clear_end", timer_clear, 1'b0);
        @(posedge mclk);
    endtask

    task setup(input logic [2:0] s, input logic fmt);
        vin <= 10'($urandom_range(1023, 0));
        ctl = {s[1:0], 3'($urandom_range(7, 0)), 3'b001};
        wr(OFS_CONFIG, {fmt, s[2], 6'h00});
        wr(OFS_CONTROL, ctl);
        set_exp(vin, fmt);
    endtask

    task finish_conv(input logic [7:0] st);
        check("channel", analog_ctl.channel_sel, ctl[5:3]);
        check("acquire", analog_ctl.acquire, 1'b1);
        rd_chk(OFS_RESULT_HIGH, 8'(exp_hi), "result_high");
        rd_chk(OFS_RESULT_LOW, 8'(exp_lo), "result_low");
        rd_chk(OFS_CONTROL, ctl, "go_cleared");
        rd_chk(OFS_IRQ_STATUS, st, "status_done");
        wr(OFS_IRQ_STATUS, st);
        @(negedge mclk);
        check("irq_cleared", irq, 1'b0);
        @(posedge mclk);
    endtask

    task do_conv(input logic [2:0] s, input logic fmt, input int n);
        setup(s, fmt);
        wr(OFS_CONTROL, ctl | 8'h04);
        wait_sig(1'b0, cyc);
        // Count starts one cycle after the accepting edge
        if (n > 0)
            check("conv_time", 32'(cyc + 1), 32'(12 * n));
        finish_conv(8'h01);
    endtask

    initial begin
        mclk = 1'b0;
        rc_clk_in = 1'b0;
        sys_rst = 1'b1;
        avs_req = '0;
        sar_cmp_in = 1'b0;
        special_trig = 1'b0;
        vin = 10'h000;
        void'($urandom(71134));
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        // Reset values and unmapped space
        for (int a = 0; a < 8; a++)
            rd_chk(5'(a * 4), 8'h00, "reset_value");
        wr(OFS_RESULT_HIGH, 8'hA5);
        wr(OFS_RESULT_LOW, 8'h5A);
        wr(5'h1C, 8'hFF);
        rd_chk(OFS_RESULT_HIGH, 8'hA5, "storage_high");
        rd_chk(OFS_RESULT_LOW, 8'h5A, "storage_low");
        rd_chk(5'h1C, 8'h00, "unmapped");
        // Go in the same write as turning on is refused
        wr(OFS_CONTROL, 8'hFF);
        rd_chk(OFS_CONTROL, 8'hF9, "control_access");
        wr(OFS_CONFIG, 8'hFF);
        rd_chk(OFS_CONFIG, 8'hCF, "config_access");
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_IRQ_MASK, 8'h01);
        // Every divided clock selection
        for (int i = 0; i < 6; i++)
            do_conv(3'(sel_tab[i]), 1'(i), div_tab[i]);
        do_conv(3'd3, 1'b1, 0);
        do_conv(3'd7, 1'b0, 0);
        // Abort mid-conversion keeps the old result
        q = 8'(exp_hi);
        setup(3'd6, 1'b1);
        wr(OFS_CONTROL, ctl | 8'h04);
        repeat (100) @(posedge mclk);
        wr(OFS_CONTROL, ctl);
        wait_sig(1'b1, cyc);
        check("abort_wait", 32'(cyc + 1), 32'(2 * 64));
        rd_chk(OFS_RESULT_HIGH, q, "abort_kept");
        rd_chk(OFS_IRQ_STATUS, 8'h00, "abort_no_done");
        rd_chk(OFS_CONTROL, ctl, "abort_go");
        wr(OFS_CONTROL, ctl | 8'h04);
        wait_sig(1'b0, cyc);
        finish_conv(8'h01);
        // Hardware start by trigger
        wr(OFS_TRIG_CFG, 8'h0B);
        setup(3'd0, 1'b0);
        trig_pulse(1'b1);
        wait_sig(1'b0, cyc);
        wr(OFS_IRQ_MASK, 8'h00);
        check("irq_masked", irq, 1'b0);
        wr(OFS_IRQ_MASK, 8'h02);
        check("irq_unmasked", irq, 1'b1);
        wr(OFS_IRQ_MASK, 8'h03);
        finish_conv(8'h03);
        // Trigger while off, or in another mode
        wr(OFS_CONTROL, 8'h00);
        trig_pulse(1'b1);
        wr(OFS_IRQ_STATUS, 8'h03);
        repeat (50) @(posedge mclk);
        rd_chk(OFS_CONTROL, 8'h00, "off_no_go");
        rd_chk(OFS_IRQ_STATUS & 5'h10, 8'h00, "off_no_done");
        wr(OFS_TRIG_CFG, 8'h0A);
        wr(OFS_CONTROL, 8'h01);
        trig_pulse(1'b0);
        rd_chk(OFS_CONTROL, 8'h01, "mode_no_go");
        // Reset in mid-conversion
        wr(OFS_CONTROL, 8'h05);
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd_chk(OFS_CONTROL, 8'h00, "reset_control");
        rd_chk(OFS_RESULT_HIGH, 8'h00, "reset_result");
        check("reset_off", analog_ctl.converter_on, 1'b0);
        print_verdict();
    end
endmodule
